// ===== design/dmr_host.sv
// Controller end: AXI4-Lite commands to the link, refresh scaling.
// Assumes the device answers every link read eventually.
`timescale 1ns/100ps
module dmr_host (
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    dmr_if.ctl               link,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    import dmr_pkg::*;

    // ----------------------------------------------------------------
    // Link clock divider
    // ----------------------------------------------------------------
    logic [3:0] div_q;
    logic       lclk_q;
    wire        half_end = (div_q == 4'(LINK_HALF_CYC - 1));
    wire        fall     = half_end & lclk_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_q  <= 4'h0;
            lclk_q <= 1'b0;
        end else begin
            div_q  <= half_end ? 4'h0 : div_q + 4'h1;
            lclk_q <= half_end ? ~lclk_q : lclk_q;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write side
    // ----------------------------------------------------------------
    typedef enum {H_IDLE, H_ISSUE, H_HOLD, H_WAIT} dmr_hst_e;
    dmr_hst_e st_q;
    logic aw_q, w_q, bv_q;
    logic [7:0]  awa_q;
    logic [31:0] wd_q;
    logic [1:0]  bresp_q;
    logic [31:0] refi_q, refipb_q, refw_q, cmd_q;
    logic [7:0]  last_rd_q;
    logic [2:0]  rate_q;
    wire aw_hs   = s_axi_awvalid & s_axi_awready;
    wire w_hs    = s_axi_wvalid & s_axi_wready;
    wire wr_go   = aw_q & w_q & ~bv_q;
    wire busy    = (st_q != H_IDLE);
    wire wr_cmd  = wr_go && (awa_q == CSR_CMD) && !busy;
    wire wr_ok   = wr_cmd || (wr_go && (awa_q == CSR_REFI || awa_q == CSR_REFIPB
                                       || awa_q == CSR_REFW));
    assign s_axi_awready = ~aw_q & ~bv_q;
    assign s_axi_wready  = ~w_q & ~bv_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0;
            awa_q <= 8'h00; wd_q <= 32'h0; bresp_q <= AXI_OKAY;
        end else begin
            if (aw_hs) begin aw_q <= 1'b1; awa_q <= s_axi_awaddr; end
            if (w_hs) begin w_q <= 1'b1; wd_q <= s_axi_wdata; end
            if (wr_go) begin
                aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b1;
                bresp_q <= wr_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready) begin
                bv_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            refi_q <= RST_REFI; refipb_q <= RST_REFIPB; refw_q <= RST_REFW;
        end else if (wr_go) begin
            if (awa_q == CSR_REFI)   refi_q   <= wd_q;
            if (awa_q == CSR_REFIPB) refipb_q <= wd_q;
            if (awa_q == CSR_REFW)   refw_q   <= wd_q;
        end
    end
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp  = bresp_q;

    // ----------------------------------------------------------------
    // Link command sequencer
    // ----------------------------------------------------------------
    wire [5:0] cmd_ma  = cmd_q[CMD_ADDR_LSB +: 6];
    wire       cmd_wr  = cmd_q[CMD_WRITE_BIT];
    // Test register only ever sees zero
    wire [7:0] cmd_op  = (cmd_ma == MA_VTEST) ? 8'h00 : cmd_q[7:0]; // R19
    logic t1_q, t2_q, t3_q, take_q;
    logic [7:0] rd1_q, rd2_q;
    wire  tgl_chg = t2_q ^ t3_q;
    dmr_cmd_e lcmd_q;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            t1_q <= 1'b0; t2_q <= 1'b0; t3_q <= 1'b0;
            rd1_q <= 8'h00; rd2_q <= 8'h00;
        end else begin
            t1_q <= link.rd_tgl; t2_q <= t1_q; t3_q <= t2_q;
            rd1_q <= link.rd_data; rd2_q <= rd1_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_q <= H_IDLE; cmd_q <= 32'h0; lcmd_q <= CMD_IDLE;
            take_q <= 1'b0; last_rd_q <= 8'h00; rate_q <= RST_RATE;
        end else begin
            take_q <= (st_q == H_WAIT) && tgl_chg;
            if (take_q) begin
                last_rd_q <= rd2_q;
                if (cmd_ma == MA_TEMP) rate_q <= rd2_q[2:0];
            end
            unique case (st_q)
                H_IDLE:  if (wr_cmd) begin cmd_q <= wd_q; st_q <= H_ISSUE; end
                H_ISSUE: if (fall) begin // R8 R20
                    lcmd_q <= cmd_wr ? CMD_MRW : CMD_MRR;
                    st_q   <= H_HOLD;
                end
                H_HOLD:  if (fall) begin
                    lcmd_q <= CMD_IDLE;
                    st_q   <= cmd_wr ? H_IDLE : H_WAIT;
                end
                H_WAIT:  if (take_q) st_q <= H_IDLE;
            endcase
        end
    end
    assign link.lk_clk  = lclk_q;
    assign link.lk_cmd  = lcmd_q;
    assign link.lk_addr = cmd_ma;
    assign link.lk_op   = cmd_op;

    // ----------------------------------------------------------------
    // Refresh scaling and read side
    // ----------------------------------------------------------------
    function automatic logic [31:0] scale(input logic [31:0] b, input logic [2:0] c);
        unique case (c)
            RR_X4:            scale = {b[29:0], 2'b00};
            RR_X2:            scale = {b[30:0], 1'b0};
            RR_HALF:          scale = {1'b0, b[31:1]};
            RR_QTR, RR_QTR_DR: scale = {2'b00, b[31:2]};
            default:          scale = b;
        endcase
    endfunction
    wire oor = (rate_q == RR_LOW) || (rate_q == RR_HIGH);
    logic        rv_q;
    logic [31:0] rdat_q;
    logic [1:0]  rresp_q;
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin // R3
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            CSR_CMD:    rd_mux = cmd_q;
            CSR_STAT:   rd_mux = {13'h0, rate_q, last_rd_q, 6'h0, oor, busy};
            CSR_REFI:   rd_mux = scale(refi_q, rate_q);
            CSR_REFIPB: rd_mux = scale(refipb_q, rate_q);
            CSR_REFW:   rd_mux = scale(refw_q, rate_q);
            default: begin rd_mux = 32'h0; rd_hit = 1'b0; end
        endcase
    end
    assign s_axi_arready = ~rv_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rv_q <= 1'b0; rdat_q <= 32'h0; rresp_q <= AXI_OKAY;
        end else if (s_axi_arvalid && !rv_q) begin
            rv_q <= 1'b1; rdat_q <= rd_mux;
            rresp_q <= rd_hit ? AXI_OKAY : AXI_SLVERR;
        end else if (s_axi_rready) begin
            rv_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rv_q;
    assign s_axi_rdata  = rdat_q;
    assign s_axi_rresp  = rresp_q;
endmodule // dmr_host

// ===== pkg/dmr_pkg.sv
// Constants for both ends of the mode-register link and the CSR map.
// Assumes both ends share one 20 MHz system clock.
//
// Overview of operation
// [R1] Address 04h mixes read status, write controls
// [R2] Bits 2:0 report refresh multiplier code
// [R3] Controller scales all three refresh intervals alike
// [R4] Bit 2 set only above 85 degrees
// [R5] Derating needed reports code 110
// [R6] Codes 000 and 111 mean out of limits
// [R7] Write to 04h changes only bits 6:3
// [R8] Bit 4 enters or exits repair mode
// [R9] Thermal offset 0/5/10 degrees, 11 reserved
// [R10] Update flag set when refresh code changes
// [R11] Reading 04h clears the update flag
// [R12] Update flag is zero after reset
// [R13] Read-only maker code at 05h
// [R14] Read-only first revision code at 06h
// [R15] Read-only second revision code at 07h
// [R16] Descriptor bits 1:0 give device type
// [R17] Descriptor bits 5:2 give die density
// [R18] Descriptor bits 7:6 give I/O width
// [R19] Controller writes only 00h to test register
// [R20] Writing bit 0 at 0Ah resets calibration
// [R21] Read drives eight bits, reserved bits zero
// [R22] Repair protection refuses repair entry writes
// [R23] Grounded calibration pin ignores calibration reset
// [R24] Sensor change updates code and flag together
package dmr_pkg;
    // ----------------------------------------------------------------
    // Mode register addresses and fields
    // ----------------------------------------------------------------
    localparam logic [5:0] MA_TEMP   = 6'h04;
    localparam logic [5:0] MA_MAKER  = 6'h05;
    localparam logic [5:0] MA_REV1   = 6'h06;
    localparam logic [5:0] MA_REV2   = 6'h07;
    localparam logic [5:0] MA_CONF   = 6'h08;
    localparam logic [5:0] MA_VTEST  = 6'h09;
    localparam logic [5:0] MA_CALRST = 6'h0a;
    localparam int TRS_ABORT_BIT  = 3;
    localparam int TRS_REPAIR_BIT = 4;
    localparam int TRS_OFFS_LSB   = 5;
    localparam int TRS_TUF_BIT    = 7;
    localparam int CAL_RST_BIT    = 0;
    localparam logic [1:0] TOFF_RSVD = 2'h3;
    localparam logic [3:0] TOFF_STEP_C = 4'h5;
    // ----------------------------------------------------------------
    // Refresh multiplier codes and temperature bands
    // ----------------------------------------------------------------
    localparam logic [2:0] RR_LOW    = 3'h0;
    localparam logic [2:0] RR_X4     = 3'h1;
    localparam logic [2:0] RR_X2     = 3'h2;
    localparam logic [2:0] RR_X1     = 3'h3;
    localparam logic [2:0] RR_HALF   = 3'h4;
    localparam logic [2:0] RR_QTR    = 3'h5;
    localparam logic [2:0] RR_QTR_DR = 3'h6;
    localparam logic [2:0] RR_HIGH   = 3'h7;
    localparam logic [2:0] RST_RATE  = RR_X1;
    localparam logic signed [7:0] TEMP_MIN_C   = -8'sd25;
    localparam logic signed [7:0] TEMP_X4_C    = 8'sd45;
    localparam logic signed [7:0] TEMP_X2_C    = 8'sd65;
    localparam logic signed [7:0] TEMP_NOM_C   = 8'sd85;
    localparam logic signed [7:0] TEMP_HALF_C  = 8'sd95;
    localparam logic signed [7:0] TEMP_QTR_C   = 8'sd105;
    // ----------------------------------------------------------------
    // Link command and timing
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {CMD_IDLE, CMD_MRR, CMD_MRW} dmr_cmd_e;
    localparam int SYS_PERIOD_NS  = 50;
    localparam int LINK_PERIOD_NS = 400;
    localparam int LINK_HALF_CYC  = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
    // ----------------------------------------------------------------
    // Controller CSR map (AXI4-Lite byte offsets)
    // ----------------------------------------------------------------
    localparam logic [7:0] CSR_CMD    = 8'h00;
    localparam logic [7:0] CSR_STAT   = 8'h04;
    localparam logic [7:0] CSR_REFI   = 8'h08;
    localparam logic [7:0] CSR_REFIPB = 8'h0c;
    localparam logic [7:0] CSR_REFW   = 8'h10;
    localparam int CMD_ADDR_LSB  = 8;
    localparam int CMD_WRITE_BIT = 16;
    localparam logic [31:0] RST_REFI   = 32'h0000_0f3c;
    localparam logic [31:0] RST_REFIPB = 32'h0000_01e7;
    localparam logic [31:0] RST_REFW   = 32'h0000_7a12;
    localparam logic [1:0] AXI_OKAY   = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
endpackage

// ===== pkg/dmr_if.sv
// Link between memory controller and mode-register bank.
// Commands change at lk_clk falling edge, sampled at the rising.
`timescale 1ns/100ps
interface dmr_if;
    logic           lk_clk;
    dmr_pkg::dmr_cmd_e lk_cmd;
    logic [5:0]     lk_addr;
    logic [7:0]     lk_op;
    logic [7:0]     rd_data;
    logic           rd_tgl;
    modport dev (input lk_clk, input lk_cmd, input lk_addr, input lk_op,
                 output rd_data, output rd_tgl);
    modport ctl (output lk_clk, output lk_cmd, output lk_addr, output lk_op,
                 input rd_data, input rd_tgl);
endinterface

// ===== design/dmr_device.sv
// Device mode-register bank: temperature status, identity,
// descriptor, test and calibration-reset registers.
// Assumes link inputs asynchronous to sys_clk and a link clock
// of at least four sys_clk cycles per half period.
`timescale 1ns/100ps
module dmr_device #(
    parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary identity value
    parameter logic [7:0] REV1_CODE  = 8'h3c, // Arbitrary identity value
    parameter logic [7:0] REV2_CODE  = 8'hc3, // Arbitrary identity value
    parameter logic [1:0] DEV_TYPE   = 2'h1,
    parameter logic [3:0] DEV_DENS   = 4'h2,
    parameter logic [1:0] DEV_WIDTH  = 2'h0
) (
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    dmr_if.dev                     link,
    input  wire logic signed [7:0] die_temp_c,
    input  wire logic              derate_req,
    input  wire logic              repair_protect,
    input  wire logic              cal_pin_grounded,
    output logic [2:0]             refresh_code,
    output logic                   out_of_limit,
    output logic                   repair_mode,
    output logic                   self_refresh_abort_en,
    output logic [3:0]             thermal_offset_c,
    output logic                   calibration_reset,
    output logic [7:0]             vendor_test_value
);
    import dmr_pkg::*;

    // ----------------------------------------------------------------
    // Link synchronisers
    // ----------------------------------------------------------------
    localparam int SW = 17;
    logic [SW-1:0] sy1_q, sy2_q;
    logic          lk_prev_q;
    wire  [SW-1:0] sy_raw = {link.lk_clk, link.lk_cmd, link.lk_addr, link.lk_op};

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sy1_q     <= '0;
            sy2_q     <= '0;
            lk_prev_q <= 1'b0;
        end else begin
            sy1_q     <= sy_raw;
            sy2_q     <= sy1_q;
            lk_prev_q <= sy2_q[SW-1];
        end
    end

    wire       lk_rise = sy2_q[SW-1] & ~lk_prev_q;
    wire [1:0] cmd_raw = sy2_q[15:14];
    wire [5:0] addr    = sy2_q[13:8];
    wire [7:0] op      = sy2_q[7:0];
    wire       is_mrr  = lk_rise && (cmd_raw == 2'(CMD_MRR));
    wire       is_mrw  = lk_rise && (cmd_raw == 2'(CMD_MRW));
    wire       wr_temp = is_mrw && (addr == MA_TEMP);
    wire       rd_temp = is_mrr && (addr == MA_TEMP);

    // ----------------------------------------------------------------
    // Temperature to refresh code
    // ----------------------------------------------------------------
    logic [2:0] rate_d;
    always_comb begin // R2
        if (die_temp_c < TEMP_MIN_C)
            rate_d = RR_LOW; // R6
        else if (die_temp_c <= TEMP_X4_C)
            rate_d = RR_X4;
        else if (die_temp_c <= TEMP_X2_C)
            rate_d = RR_X2;
        else if (die_temp_c <= TEMP_NOM_C)
            rate_d = RR_X1; // R4
        else if (die_temp_c <= TEMP_HALF_C)
            rate_d = RR_HALF;
        else if (die_temp_c <= TEMP_QTR_C)
            rate_d = derate_req ? RR_QTR_DR : RR_QTR; // R5
        else
            rate_d = RR_HIGH; // R6
    end

    // ----------------------------------------------------------------
    // Temperature status register
    // ----------------------------------------------------------------
    logic [2:0] rate_q;
    logic       tuf_q;
    logic       abort_q;
    logic       repair_q;
    logic [1:0] offs_q;
    wire        rate_chg  = (rate_d != rate_q);
    wire [1:0]  offs_wr   = op[TRS_OFFS_LSB +: 2];
    // Protection blocks entry only; exit stays possible
    wire        repair_ok = ~(op[TRS_REPAIR_BIT] & repair_protect); // R22

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rate_q <= RST_RATE;
            tuf_q  <= 1'b0; // R12
        end else begin
            rate_q <= rate_d; // R24
            if (rate_chg)
                tuf_q <= 1'b1; // R10 R24
            else if (rd_temp)
                tuf_q <= 1'b0; // R11
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            abort_q  <= 1'b0;
            repair_q <= 1'b0;
            offs_q   <= 2'h0;
        end else if (wr_temp) begin // R7
            abort_q <= op[TRS_ABORT_BIT];
            if (repair_ok)
                repair_q <= op[TRS_REPAIR_BIT]; // R8 R22
            // Reserved offset code leaves the old offset in force
            if (offs_wr != TOFF_RSVD)
                offs_q <= offs_wr; // R9
        end
    end

    // ----------------------------------------------------------------
    // Write-only test and calibration registers
    // ----------------------------------------------------------------
    logic [7:0] vtest_q;
    logic       calrst_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            vtest_q  <= 8'h00;
            calrst_q <= 1'b0;
        end else begin
            if (is_mrw && addr == MA_VTEST)
                vtest_q <= op;
            calrst_q <= is_mrw && (addr == MA_CALRST) && op[CAL_RST_BIT]
                        && !cal_pin_grounded; // R20 R23
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin // R21
        unique case (addr)
            MA_TEMP:  rd_mux = {tuf_q, 4'h0, rate_q}; // R1
            MA_MAKER: rd_mux = MAKER_CODE; // R13
            MA_REV1:  rd_mux = REV1_CODE; // R14
            MA_REV2:  rd_mux = REV2_CODE; // R15
            MA_CONF:  rd_mux = {DEV_WIDTH, DEV_DENS, DEV_TYPE}; // R16 R17 R18
            default:  rd_mux = 8'h00;
        endcase
    end

    logic [7:0] rd_data_q;
    logic       rd_tgl_q;
    // Data changes in the toggle's cycle; the reader waits one more cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rd_data_q <= 8'h00;
            rd_tgl_q  <= 1'b0;
        end else if (is_mrr) begin
            rd_data_q <= rd_mux;
            rd_tgl_q  <= ~rd_tgl_q;
        end
    end

    assign link.rd_data          = rd_data_q;
    assign link.rd_tgl           = rd_tgl_q;
    assign refresh_code          = rate_q;
    assign out_of_limit          = (rate_q == RR_LOW) || (rate_q == RR_HIGH); // R6
    assign repair_mode           = repair_q;
    assign self_refresh_abort_en = abort_q;
    assign thermal_offset_c      = 4'(offs_q * TOFF_STEP_C); // R9
    assign calibration_reset     = calrst_q;
    assign vendor_test_value     = vtest_q;
endmodule // dmr_device

// ===== tb/dmr_link_sva.sv
// Checker for the mode-register link.
// Assumes one sys_clk domain; placed beside the link interface.
`timescale 1ns/100ps
module dmr_link_sva #(
    parameter logic [7:0] CONF_VAL = 8'h09
) (
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire logic              lk_clk,
    input wire dmr_pkg::dmr_cmd_e lk_cmd,
    input wire logic [5:0]        lk_addr,
    input wire logic [7:0]        lk_op,
    input wire logic [7:0]        rd_data,
    input wire logic              rd_tgl
);
    import dmr_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Link steps
    // ----------------------------------------------------------------
    sequence s_mrr_rise;
        lk_cmd == CMD_MRR && $rose(lk_clk);
    endsequence
    sequence s_served;
        $changed(rd_tgl);
    endsequence
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    a_vtest_zero_op: assert property (
        lk_cmd == CMD_MRW && lk_addr == MA_VTEST |-> lk_op == 8'h00)
        else $error("test register written nonzero");
    a_mrr_answered: assert property (
        s_mrr_rise |-> ##[1:6] s_served)
        else $error("read command not answered");
    a_data_with_tgl: assert property (
        $changed(rd_data) |-> $changed(rd_tgl))
        else $error("read data moved without a read");
    a_temp_wo_zero: assert property (
        s_served ##0 lk_addr == MA_TEMP |-> rd_data[6:3] == 4'h0)
        else $error("write-only status bits read nonzero");
    a_wo_regs_zero: assert property (
        s_served ##0 (lk_addr == MA_VTEST || lk_addr == MA_CALRST) |-> rd_data == 8'h00)
        else $error("write-only register read nonzero");
    a_conf_value: assert property (
        s_served ##0 lk_addr == MA_CONF |-> rd_data == CONF_VAL)
        else $error("descriptor read wrong");
    a_clk_half: assert property (
        $rose(lk_clk) |=> lk_clk [*3] ##1 !lk_clk)
        else $error("link clock high phase wrong");
    a_cmd_period: assert property (
        $changed(lk_cmd) && lk_cmd != CMD_IDLE |=> $stable(lk_cmd) [*7] ##1 lk_cmd == CMD_IDLE)
        else $error("command not held one link period");
endmodule // dmr_link_sva

// ===== tb/tb.sv
// Bench: controller and device on one link, driven over AXI4-Lite.
// Assumes the device's default parameters.
`timescale 1ns/100ps
module tb;
    import dmr_pkg::*;
    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic              sys_clk = 1'b0;
    logic              sys_rst;
    logic signed [7:0] die_temp_c;
    logic              derate_req, repair_protect, cal_pin_grounded;
    logic [2:0]        refresh_code;
    logic [3:0]        thermal_offset_c, s_axi_wstrb;
    logic [7:0]        vendor_test_value, s_axi_awaddr, s_axi_araddr;
    logic              out_of_limit, repair_mode, self_refresh_abort_en, calibration_reset;
    logic [31:0]       s_axi_wdata, s_axi_rdata;
    logic [1:0]        s_axi_bresp, s_axi_rresp;
    logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int                errors, samples_checked, cal_pulses;
    localparam logic [5:0] RO_ADDR [6] = '{MA_MAKER, MA_REV1, MA_REV2, MA_CONF, MA_VTEST, MA_CALRST};
    localparam logic [7:0] RO_VAL [6] = '{8'h5a, 8'h3c, 8'hc3, 8'h09, 8'h00, 8'h00};
    // Band edges probed at their limits
    localparam logic signed [7:0] TEMPS [8] = '{-8'sd26, 8'sd45, 8'sd65, 8'sd85, 8'sd86,
                                                8'sd105, 8'sd105, 8'sd106};
    localparam logic [7:0]  BASE_ADDR [3] = '{CSR_REFI, CSR_REFIPB, CSR_REFW};
    localparam logic [31:0] BASE_RST [3] = '{RST_REFI, RST_REFIPB, RST_REFW};
    dmr_if u_dmr_if ();
    dmr_device u_dmr_device (.*, .link(u_dmr_if.dev));
    dmr_host u_dmr_host (.*, .link(u_dmr_if.ctl));
    dmr_link_sva u_dmr_link_sva (.sys_clk, .sys_rst, .lk_clk(u_dmr_if.lk_clk),
        .lk_cmd(u_dmr_if.lk_cmd), .lk_addr(u_dmr_if.lk_addr), .lk_op(u_dmr_if.lk_op),
        .rd_data(u_dmr_if.rd_data), .rd_tgl(u_dmr_if.rd_tgl));
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (calibration_reset === 1'b1) cal_pulses++;
    // ----------------------------------------------------------------
    // Tasks and tests
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic wait_idle(output logic [31:0] s);
        logic [1:0] r;
        do axi_rd(CSR_STAT, s, r); while (s[0] !== 1'b0);
    endtask
    task automatic mr_cmd(input logic wr, input logic [5:0] a, input logic [7:0] op,
                          output logic [7:0] rd);
        logic [31:0] s;
        logic [1:0]  r;
        axi_wr(CSR_CMD, {15'h0, wr, 2'h0, a, op}, r);
        wait_idle(s);
        rd = s[15:8];
    endtask
    task automatic set_temp(input logic signed [7:0] t, input logic dr);
        die_temp_c <= t;
        derate_req <= dr;
        repeat (3) @(posedge sys_clk);
    endtask
    function automatic logic [31:0] scaled(input logic [31:0] b, input logic [2:0] c);
        return c == RR_X4 ? b << 2 : c == RR_X2 ? b << 1 : c == RR_HALF ? b >> 1 :
               c inside {RR_QTR, RR_QTR_DR} ? b >> 2 : b;
    endfunction
    task automatic tally_and_finish;
        $display("Checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #2_000_000;
        errors++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish();
    end
    initial begin
        logic [7:0]  rd;
        logic [31:0] d;
        logic [1:0]  r;
        {errors, samples_checked, cal_pulses} = '0;
        {sys_rst, s_axi_bready, s_axi_rready} = 3'b111;
        {derate_req, repair_protect, cal_pin_grounded, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        die_temp_c = 8'sd80;
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        chk({repair_mode, self_refresh_abort_en, thermal_offset_c, refresh_code}, 32'h3);
        mr_cmd(1'b0, MA_TEMP, 8'h00, rd);
        chk(rd, {5'h0, RST_RATE});
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            mr_cmd(1'b0, RO_ADDR[i], 8'h00, rd);
            chk(rd, RO_VAL[i]);
        end
        $display("test identity done");
        for (int i = 0; i < 8; i++) begin
            set_temp(TEMPS[i], i == 6);
            chk(refresh_code, i[2:0]);
            chk(out_of_limit, i == 0 || i == 7);
            mr_cmd(1'b0, MA_TEMP, 8'h00, rd);
            chk(rd, {5'h10, i[2:0]});
            mr_cmd(1'b0, MA_TEMP, 8'h00, rd);
            chk(rd, {5'h00, i[2:0]});
            for (int k = 0; k < 3; k++) begin
                axi_rd(BASE_ADDR[k], d, r);
                chk(d, scaled(BASE_RST[k], i[2:0]));
            end
        end
        $display("test refresh bands done");
        set_temp(8'sd80, 1'b0);
        mr_cmd(1'b1, MA_TEMP, 8'hbf, rd);
        chk({thermal_offset_c, repair_mode, self_refresh_abort_en, refresh_code}, 9'h0bb);
        mr_cmd(1'b1, MA_TEMP, 8'h40, rd);
        chk({thermal_offset_c, repair_mode, self_refresh_abort_en}, 6'h28);
        repair_protect <= 1'b1;
        mr_cmd(1'b1, MA_TEMP, 8'h70, rd);
        chk({thermal_offset_c, repair_mode, self_refresh_abort_en}, 6'h28);
        mr_cmd(1'b1, MA_VTEST, 8'ha5, rd);
        chk(vendor_test_value, 8'h00);
        mr_cmd(1'b1, MA_CALRST, 8'h00, rd);
        chk(cal_pulses, 0);
        mr_cmd(1'b1, MA_CALRST, 8'h01, rd);
        chk(cal_pulses, 1);
        cal_pin_grounded <= 1'b1;
        mr_cmd(1'b1, MA_CALRST, 8'h01, rd);
        chk(cal_pulses, 1);
        $display("test writes done");
        axi_rd(8'h40, d, r);
        chk({r, d[29:0]}, {AXI_SLVERR, 30'h0});
        axi_wr(8'h40, 32'h1, r);
        chk(r, AXI_SLVERR);
        axi_wr(CSR_CMD, 32'h0000_0400, r);
        axi_wr(CSR_CMD, 32'h0000_0400, r);
        chk(r, AXI_SLVERR);
        wait_idle(d);
        axi_wr(CSR_REFW, 32'h0000_0100, r);
        axi_rd(CSR_REFW, d, r);
        chk({r, d[29:0]}, {AXI_OKAY, 30'h100});
        $display("test refusals done");
        tally_and_finish();
    end
endmodule // tb
